// File: verilog/ddrsq_top.sv
`timescale 1ns/1ps
`include "ddrsq_defines.svh"
module ddrsq_top import ddrsq_pkg::*; #(
   parameter int DLLK_CK = `DDRSQ_DLLK_CK,
   parameter int TCKSRE_CYC = `DDRSQ_TCKSRE_CYC
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // avalon-mm slave
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // command pins from the memory controller
   input wire logic i_ck,
   input wire logic i_cke,
   input wire logic i_cs_b,
   input wire logic i_ras_b,
   input wire logic i_cas_b,
   input wire logic i_we_b,
   input wire logic [2:0] i_ba,
   input wire logic [12:0] i_addr,
   input wire logic i_odt,
   // strobes, taken as the true half of each pair
   input wire logic i_upper_lane_strobe_pair,
   input wire logic i_lower_lane_strobe_pair,
   // data pins and termination
   output logic [15:0] o_dq,
   output logic [15:0] o_dq_oe_b,
   output logic o_dqs_term_on,
   output logic o_dq_term_on
);
   localparam int PW = 25;

   logic [PW-1:0] sync1_r, sync2_r;
   logic ck_s, cke_s, odt_s;
   logic [3:0] cmdp_s;
   logic [2:0] ba_s;
   logic [12:0] addr_s;
   logic [1:0] dqs_s;
   logic ck_d_r, cke_prev_r, ck_rise, ck_use;
   ddrsq_cmd_e cmd;
   logic cmd_valid;
   ddrsq_state_e st_r;
   logic [7:0] cksre_cnt_r;
   logic clk_free_r;
   logic [12:0] mr0_r, mr1_r;
   logic [15:0] lock_cnt_r;
   logic dll_locked_r;
   logic dll_en, wl_on, qoff, rtt_nom_en;
   logic ctrl_alldq_r;
   logic [2:0] err_r, err_set, err_clr;
   logic ack_r;
   logic [31:0] rd_nxt;
   logic [15:0] dq_nxt;

   ddrsq_lvl_if #(.LANES(2)) lvl_if ();

   // two-stage synchroniser for every pin, ck included
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {i_ck, i_cke, i_cs_b, i_ras_b, i_cas_b, i_we_b, i_ba,
            i_addr, i_odt, i_upper_lane_strobe_pair,
            i_lower_lane_strobe_pair};
         sync2_r <= sync1_r;
      end
   end

   // pins sample together; controller keeps setup around ck edges
   assign {ck_s, cke_s, cmdp_s, ba_s, addr_s, odt_s, dqs_s} = sync2_r;

   // command decode from the four control pins
   function automatic ddrsq_cmd_e cmd_of(input logic [3:0] p);
      if (p[3]) begin
         cmd_of = DDRSQ_CMD_DES;
      end else if (p[2:0] == 3'h7) begin
         cmd_of = DDRSQ_CMD_NOP;
      end else if (p[2:0] == 3'h0) begin
         cmd_of = DDRSQ_CMD_MRS;
      end else if (p[2:0] == 3'h1) begin
         cmd_of = DDRSQ_CMD_REF;
      end else begin
         cmd_of = DDRSQ_CMD_OTHER;
      end
   endfunction

   // ck edge detect; edges with cke low are dropped once the clock is free
   assign ck_rise = ck_s && !ck_d_r;
   assign ck_use = ck_rise && !(clk_free_r && !cke_s);
   assign cmd = cmd_of(cmdp_s);
   assign cmd_valid = ck_use && cke_prev_r && cke_s && (st_r == DDRSQ_ST_IDLE);

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ck_d_r <= 1'b0;
         cke_prev_r <= 1'b0;
      end else begin
         ck_d_r <= ck_s;
         if (ck_use) begin
            cke_prev_r <= cke_s;
         end
      end
   end

   // power state: self refresh and precharge power-down
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r <= DDRSQ_ST_IDLE;
      end else begin
         case (st_r)
            DDRSQ_ST_IDLE: begin
               if (ck_use && cke_prev_r && !cke_s) begin
                  st_r <= (cmd == DDRSQ_CMD_REF) ? DDRSQ_ST_SREF :
                     DDRSQ_ST_PDN;
               end
            end
            DDRSQ_ST_SREF, DDRSQ_ST_PDN: begin
               if (ck_use && cke_s) begin
                  st_r <= DDRSQ_ST_IDLE;
               end
            end
            default: st_r <= DDRSQ_ST_IDLE;
         endcase
      end
   end

   // tcksre timer; after it the clock may stop or change
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cksre_cnt_r <= 8'h00;
         clk_free_r <= 1'b0;
      end else if (st_r == DDRSQ_ST_IDLE || cke_s) begin
         cksre_cnt_r <= 8'h00;
         clk_free_r <= 1'b0;
      end else if (cksre_cnt_r == 8'(TCKSRE_CYC - 1)) begin
         clk_free_r <= 1'b1;
      end else begin
         cksre_cnt_r <= cksre_cnt_r + 8'h01;
      end
   end

   // mode registers; the whole word applies, incl. leveling exit
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mr0_r <= `DDRSQ_MR0_RST;
         mr1_r <= `DDRSQ_MR1_RST;
      end else if (cmd_valid && cmd == DDRSQ_CMD_MRS) begin
         if (ba_s == 3'h0) begin
            mr0_r <= addr_s;
         end else if (ba_s == 3'h1) begin
            mr1_r <= addr_s;
         end
      end
   end

   assign dll_en = !mr1_r[`DDRSQ_MR1_DLLDIS];
   assign wl_on = mr1_r[`DDRSQ_MR1_WLVL];
   assign qoff = mr1_r[`DDRSQ_MR1_QOFF];
   assign rtt_nom_en = mr1_r[9] || mr1_r[6] || mr1_r[2];

   // dll reset and relock over DLLK_CK clock edges
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lock_cnt_r <= 16'h0000;
         dll_locked_r <= 1'b0;
      end else if (!dll_en) begin
         lock_cnt_r <= 16'h0000;
         dll_locked_r <= 1'b0;
      end else if (cmd_valid && cmd == DDRSQ_CMD_MRS && ba_s == 3'h0 &&
            addr_s[`DDRSQ_MR0_DLLRST]) begin
         lock_cnt_r <= 16'(DLLK_CK);
         dll_locked_r <= 1'b0;
      end else if (lock_cnt_r != 16'h0000 && ck_use) begin
         lock_cnt_r <= lock_cnt_r - 16'h0001;
         dll_locked_r <= (lock_cnt_r == 16'h0001);
      end
   end

   // protocol watch: cke drop in relock, bad leveling cmd, odt in pdn
   always_comb begin
      err_set = 3'b000;
      err_set[`DDRSQ_ERR_CKE] = ck_rise && !cke_s &&
         lock_cnt_r != 16'h0000;
      err_set[`DDRSQ_ERR_WLCMD] = cmd_valid && wl_on &&
         !(cmd == DDRSQ_CMD_NOP || cmd == DDRSQ_CMD_DES ||
         (cmd == DDRSQ_CMD_MRS && ba_s == 3'h1));
      err_set[`DDRSQ_ERR_PDODT] = st_r == DDRSQ_ST_PDN && odt_s &&
         rtt_nom_en;
   end

   // sticky errors, write one to clear; a new event beats the clear
   assign err_clr = (ack_r && i_avs_write && i_avs_address ==
      `DDRSQ_REG_ERR) ? i_avs_writedata[2:0] : 3'b000;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         err_r <= 3'b000;
      end else begin
         err_r <= (err_r & ~err_clr) | err_set;
      end
   end

   // termination: off when powered down, strobes only in leveling
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_dqs_term_on <= 1'b0;
         o_dq_term_on <= 1'b0;
      end else if (st_r != DDRSQ_ST_IDLE) begin
         o_dqs_term_on <= 1'b0;
         o_dq_term_on <= 1'b0;
      end else if (wl_on) begin
         o_dqs_term_on <= odt_s;
         o_dq_term_on <= 1'b0;
      end else begin
         o_dqs_term_on <= odt_s && rtt_nom_en;
         o_dq_term_on <= odt_s && rtt_nom_en;
      end
   end

   // leveling sampler
   assign lvl_if.dqs_s = dqs_s; // lanes stay independent, both may rise
   assign lvl_if.ck_s = ck_s;
   assign lvl_if.wl_on = wl_on;

   ddrsq_wlvl #(.LANES(2)) u_wlvl (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .lvl(lvl_if.lvl)
   );

   // feedback on the prime bit of each lane, or on all bits
   always_comb begin
      dq_nxt = 16'h0000;
      for (int l = 0; l < 2; l++) begin
         dq_nxt[l*8] = lvl_if.fb[l];
         for (int b = 1; b < 8; b++) begin
            dq_nxt[l*8+b] = ctrl_alldq_r && lvl_if.fb[l];
         end
      end
   end

   // data pins drive only in leveling with the output buffer on
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_dq <= 16'h0000;
         o_dq_oe_b <= 16'hffff;
      end else if (wl_on && !qoff) begin
         o_dq <= dq_nxt;
         o_dq_oe_b <= 16'h0000;
      end else begin
         o_dq <= 16'h0000;
         o_dq_oe_b <= 16'hffff;
      end
   end

   // bus: one wait cycle, then the access completes
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;

   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (i_avs_address == `DDRSQ_REG_CTRL) begin
         rd_nxt[0] = ctrl_alldq_r;
      end else if (i_avs_address == `DDRSQ_REG_STATUS) begin
         rd_nxt[9:0] = {lvl_if.fb, clk_free_r, qoff, wl_on, dll_locked_r,
            dll_en, st_r};
      end else if (i_avs_address == `DDRSQ_REG_MR0) begin
         rd_nxt[12:0] = mr0_r;
      end else if (i_avs_address == `DDRSQ_REG_MR1) begin
         rd_nxt[12:0] = mr1_r;
      end else if (i_avs_address == `DDRSQ_REG_ERR) begin
         rd_nxt[2:0] = err_r;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ack_r <= 1'b0;
         o_avs_readdata <= 32'h0000_0000;
         ctrl_alldq_r <= `DDRSQ_CTRL_RST;
      end else begin
         ack_r <= (i_avs_read || i_avs_write) && !ack_r;
         if (i_avs_read && !ack_r) begin
            o_avs_readdata <= rd_nxt;
         end
         if (ack_r && i_avs_write && i_avs_address == `DDRSQ_REG_CTRL) begin
            ctrl_alldq_r <= i_avs_writedata[`DDRSQ_CTRL_ALLDQ];
         end
      end
   end
endmodule

// File: shared/ddrsq_defines.svh
`ifndef DDRSQ_DEFINES_SVH
`define DDRSQ_DEFINES_SVH
// Behaviour
// - txs after exit, mode register 1 bit 0 low enables the DLL.
// - tMRD later, mode register 0 bit 8 high starts a DLL reset.
// - in self refresh the device ignores the clock after tcksre.
// - in precharge power-down termination stays off regardless of ODT.
// - mode register 1 bit 7 high enters, low leaves write leveling.
// - in leveling ODT switches strobe termination only, data stays off.
// - leveling exit write may also change bits 12,9,6-5,2-1.
// - strobe rise samples clock; result on data pins after twlo.
// - each byte lane reports its own strobe against the clock.

// register byte addresses
`define DDRSQ_REG_CTRL 5'h00
`define DDRSQ_REG_STATUS 5'h04
`define DDRSQ_REG_MR0 5'h08
`define DDRSQ_REG_MR1 5'h0c
`define DDRSQ_REG_ERR 5'h10
// field positions
`define DDRSQ_CTRL_ALLDQ 0
`define DDRSQ_MR0_DLLRST 8
`define DDRSQ_MR1_DLLDIS 0
`define DDRSQ_MR1_WLVL 7
`define DDRSQ_MR1_QOFF 12
`define DDRSQ_ERR_CKE 0
`define DDRSQ_ERR_WLCMD 1
`define DDRSQ_ERR_PDODT 2
// reset values
`define DDRSQ_MR0_RST 13'h0000
`define DDRSQ_MR1_RST 13'h0000
`define DDRSQ_CTRL_RST 1'b0
// timing
`define DDRSQ_MCLK_PS 4000
`define DDRSQ_TCKSRE_PS 10000
`define DDRSQ_TCKSRE_CYC \
   ((`DDRSQ_TCKSRE_PS + `DDRSQ_MCLK_PS - 1) / `DDRSQ_MCLK_PS)
`define DDRSQ_TWLO_PS 7500
`define DDRSQ_TWLO_CYC ((`DDRSQ_TWLO_PS / `DDRSQ_MCLK_PS) < 1 ? 1 : \
   (`DDRSQ_TWLO_PS / `DDRSQ_MCLK_PS))
`define DDRSQ_DLLK_CK 512
`endif

// File: shared/ddrsq_pkg.sv
package ddrsq_pkg;
   // power state of the device
   typedef enum logic [2:0] {
      DDRSQ_ST_IDLE = 3'b001,
      DDRSQ_ST_SREF = 3'b010,
      DDRSQ_ST_PDN = 3'b100
   } ddrsq_state_e;
   // decoded command on a clock edge
   typedef enum logic [2:0] {
      DDRSQ_CMD_DES = 3'h0,
      DDRSQ_CMD_NOP = 3'h1,
      DDRSQ_CMD_MRS = 3'h2,
      DDRSQ_CMD_REF = 3'h3,
      DDRSQ_CMD_OTHER = 3'h4
   } ddrsq_cmd_e;
endpackage

// File: shared/ddrsq_lvl_if.sv
`timescale 1ns/1ps
interface ddrsq_lvl_if #(parameter int LANES = 2);
   logic [LANES-1:0] dqs_s;
   logic ck_s;
   logic wl_on;
   logic [LANES-1:0] fb;
   modport ctl (output dqs_s, output ck_s, output wl_on, input fb);
   modport lvl (input dqs_s, input ck_s, input wl_on, output fb);
endinterface

// File: verilog/ddrsq_wlvl.sv
`timescale 1ns/1ps
`include "ddrsq_defines.svh"
module ddrsq_wlvl import ddrsq_pkg::*; #(
   parameter int LANES = 2,
   parameter int TWLO_CYC = `DDRSQ_TWLO_CYC
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // link to the controller side
   ddrsq_lvl_if.lvl lvl
);
   logic [LANES-1:0] dqs_d_r;
   logic [LANES-1:0] samp_r;
   logic [LANES-1:0] fb_r;
   logic [LANES-1:0][7:0] cnt_r;

   assign lvl.fb = fb_r;

   // strobe edge history
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         dqs_d_r <= '0;
      end else begin
         dqs_d_r <= lvl.dqs_s;
      end
   end

   // per lane: sample clock on strobe rise, publish after twlo
   // sampling resolution is one system clock, far finer than tCK here
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         samp_r <= '0;
         fb_r <= '0;
         cnt_r <= '0;
      end else begin
         for (int i = 0; i < LANES; i++) begin
            if (!lvl.wl_on) begin
               samp_r[i] <= 1'b0;
               fb_r[i] <= 1'b0;
               cnt_r[i] <= 8'h00;
            end else if (lvl.dqs_s[i] && !dqs_d_r[i]) begin
               samp_r[i] <= lvl.ck_s;
               cnt_r[i] <= 8'(TWLO_CYC);
            end else if (cnt_r[i] == 8'h01) begin
               fb_r[i] <= samp_r[i];
               cnt_r[i] <= 8'h00;
            end else if (cnt_r[i] != 8'h00) begin
               cnt_r[i] <= cnt_r[i] - 8'h01;
            end
         end
      end
   end
endmodule

// File: tb/ddrsq_top_props.sv
`timescale 1ns/1ps
module ddrsq_top_props #(
   parameter int DLLK_CK = 512,
   parameter int TCKSRE_CYC = 3
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // register bus
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // device pins
   input wire logic i_odt,
   input wire logic i_upper_lane_strobe_pair,
   input wire logic i_lower_lane_strobe_pair,
   input wire logic [15:0] o_dq,
   input wire logic [15:0] o_dq_oe_b,
   input wire logic o_dqs_term_on,
   input wire logic o_dq_term_on
);
   logic [7:0] lo_age_r;
   logic [7:0] hi_age_r;
   logic [7:0] odt_lo_r;
   logic [7:0] odt_hi_r;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b);
   // strobe ages, saturating so an old rise never looks fresh
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lo_age_r <= 8'hff;
         hi_age_r <= 8'hff;
      end else begin
         lo_age_r <= $rose(i_lower_lane_strobe_pair) ? 8'h00 :
            lo_age_r + {7'h0, lo_age_r != 8'hff};
         hi_age_r <= $rose(i_upper_lane_strobe_pair) ? 8'h00 :
            hi_age_r + {7'h0, hi_age_r != 8'hff};
      end
   end
   // odt runs; link clock is slow, 100 cycles spans two of its rises
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         odt_lo_r <= 8'h00;
         odt_hi_r <= 8'h00;
      end else begin
         odt_lo_r <= i_odt ? 8'h00 : odt_lo_r + {7'h0, odt_lo_r != 8'hff};
         odt_hi_r <= (i_odt && !o_dq_oe_b[0]) ?
            odt_hi_r + {7'h0, odt_hi_r != 8'hff} : 8'h00;
      end
   end
   sequence bus_start;
      $rose(i_avs_read || i_avs_write);
   endsequence
   sequence one_wait;
      o_avs_waitrequest ##1 !o_avs_waitrequest;
   endsequence
   one_wait_a: assert property (bus_start |-> one_wait)
      else $error("bus request without a single wait cycle");
   rdata_hold_a: assert property (!i_avs_read |-> $stable(o_avs_readdata))
      else $error("read data moved without a read");
   lower_fb_a: assert property ($rose(o_dq[0]) |->
      lo_age_r > 8'h00 && lo_age_r < 8'h0c)
      else $error("lower feedback rose without a lower strobe");
   upper_fb_a: assert property ($rose(o_dq[8]) |->
      hi_age_r > 8'h00 && hi_age_r < 8'h0c)
      else $error("upper feedback rose without an upper strobe");
   quiet_bits_a: assert property (
      (o_dq[7:1] == 7'h00 || o_dq[7:1] == {7{o_dq[0]}}) &&
      (o_dq[15:9] == 7'h00 || o_dq[15:9] == {7{o_dq[8]}}))
      else $error("non feedback data bits not low or copied");
   oe_whole_a: assert property (o_dq_oe_b == 16'h0000 ||
      o_dq_oe_b == 16'hffff)
      else $error("data enables split");
   dq_term_a: assert property (!o_dq_oe_b[0] |-> !o_dq_term_on)
      else $error("data termination on while feeding back");
   odt_off_a: assert property (odt_lo_r >= 8'h64 |->
      !o_dqs_term_on && !o_dq_term_on)
      else $error("termination on with odt low");
   dqs_term_a: assert property (odt_hi_r >= 8'h64 |-> o_dqs_term_on)
      else $error("strobe termination off with odt high");
endmodule
bind ddrsq_top ddrsq_top_props #(
   .DLLK_CK(DLLK_CK),
   .TCKSRE_CYC(TCKSRE_CYC)
) ddrsq_top_props_inst (
   .i_mclk(i_mclk), .i_rst_b(i_rst_b),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .i_odt(i_odt), .i_upper_lane_strobe_pair(i_upper_lane_strobe_pair),
   .i_lower_lane_strobe_pair(i_lower_lane_strobe_pair), .o_dq(o_dq),
   .o_dq_oe_b(o_dq_oe_b), .o_dqs_term_on(o_dqs_term_on),
   .o_dq_term_on(o_dq_term_on)
);

// File: tb/ddrsq_ctl_model.sv
`timescale 1ns/1ps
module ddrsq_ctl_model (
   // system clock
   input wire logic i_mclk,
   // pins toward the device
   output logic o_ck,
   output logic o_cke,
   output logic [3:0] o_cmd_b,
   output logic [2:0] o_ba,
   output logic [12:0] o_addr,
   output logic o_odt,
   output logic [1:0] o_dqs
);
   // link clock free running, phase offset from the system clock
   initial begin
      o_ck = 1'b0;
      o_cke = 1'b1;
      o_cmd_b = 4'hf;
      o_ba = 3'h0;
      o_addr = 13'h0000;
      o_odt = 1'b0;
      o_dqs = 2'b00;
      #1.3;
      forever #80 o_ck = ~o_ck;
   end
   // command held over one link rise, then deselect with bus scrambled
   task automatic send(input logic [3:0] c, input logic [2:0] b,
      input logic [12:0] a, input logic k);
      @(negedge o_ck);
      @(posedge i_mclk);
      o_cmd_b <= c;
      o_ba <= b;
      o_addr <= a;
      o_cke <= k;
      @(negedge o_ck);
      @(posedge i_mclk);
      o_cmd_b <= 4'hf;
      o_ba <= ~b;
      o_addr <= ~a;
   endtask
   task automatic odt_set(input logic v);
      @(posedge i_mclk);
      o_odt <= v;
   endtask
   // single strobe rise d cycles after a link rise; lvl is ck there
   task automatic pulse(input int ln, input int d, output logic lvl);
      @(posedge o_ck);
      repeat (d) @(posedge i_mclk);
      lvl = o_ck;
      o_dqs[ln] <= 1'b1;
      repeat (4) @(posedge i_mclk);
      o_dqs[ln] <= 1'b0;
   endtask
endmodule

// File: tb/tb_ddrsq_top.sv
`timescale 1ns/1ps
module tb_ddrsq_top;
   logic mclk = 1'b0;
   logic rst_b;
   logic [4:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] readdata;
   logic waitreq;
   logic ck, cke, odt;
   logic [3:0] cmd_b;
   logic [2:0] ba;
   logic [12:0] addr;
   logic [1:0] dqs;
   logic [15:0] dq, dq_oe_b;
   logic dqs_term, dq_term;
   logic [31:0] rdata, v;
   logic [7:0] fb[2];
   logic alldq, lvl;
   int err_total = 0;
   int samples_checked = 0;
   int mr1_m = 0, st_m = 1, lock_m = 0, free_m = 0, dly;
   always #2 mclk = ~mclk;
   ddrsq_ctl_model ddrsq_ctl_model_inst (.i_mclk(mclk), .o_ck(ck),
      .o_cke(cke), .o_cmd_b(cmd_b), .o_ba(ba), .o_addr(addr), .o_odt(odt),
      .o_dqs(dqs));
   ddrsq_top #(.DLLK_CK(8)) ddrsq_top_inst (
      .i_mclk(mclk), .i_rst_b(rst_b), .i_avs_address(avs_address),
      .i_avs_read(avs_read), .i_avs_write(avs_write),
      .i_avs_writedata(avs_writedata), .o_avs_readdata(readdata),
      .o_avs_waitrequest(waitreq), .i_ck(ck), .i_cke(cke),
      .i_cs_b(cmd_b[3]), .i_ras_b(cmd_b[2]), .i_cas_b(cmd_b[1]),
      .i_we_b(cmd_b[0]), .i_ba(ba), .i_addr(addr), .i_odt(odt),
      .i_upper_lane_strobe_pair(dqs[1]), .i_lower_lane_strobe_pair(dqs[0]),
      .o_dq(dq), .o_dq_oe_b(dq_oe_b), .o_dqs_term_on(dqs_term),
      .o_dq_term_on(dq_term));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one bus transfer; read data taken at the completing edge
   task automatic av(input logic w, input logic [4:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avs_read <= ~w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (waitreq !== 1'b0 && n < 40);
      if (waitreq !== 1'b0)
         err_total++;
      rdata = readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic stat(input logic [31:0] m);
      logic [31:0] e;
      e = {24'h0, free_m[0], mr1_m[12], mr1_m[7], lock_m[0], ~mr1_m[0],
         st_m[2:0]};
      av(1'b0, 5'h04, 32'h0);
      check(rdata & m, e & m);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge mclk);
      err_total++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h56e71c2d));
      fb[0] = 8'h00;
      fb[1] = 8'h00;
      rst_b = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      // reset values, read-only write, unmapped address
      av(1'b1, 5'h08, 32'h1fff);
      for (int i = 0; i < 6; i++) begin
         av(1'b0, 5'(i * 4), 32'h0);
         check(rdata, (i == 1) ? 32'h9 : 32'h0);
      end
      check({16'h0, dq_oe_b}, 32'hffff);
      $display("test registers done");
      // dll off, self refresh, exit, enable and reset the dll
      ddrsq_ctl_model_inst.send(4'h0, 3'h1, 13'h0001, 1'b1);
      mr1_m = 1;
      stat(32'hff);
      ddrsq_ctl_model_inst.send(4'h1, 3'h0, 13'h0, 1'b0);
      st_m = 2;
      free_m = 1;
      stat(32'hff);
      ddrsq_ctl_model_inst.send(4'h7, 3'h0, 13'h0, 1'b1);
      st_m = 1;
      free_m = 0;
      ddrsq_ctl_model_inst.send(4'h0, 3'h1, 13'h0000, 1'b1);
      mr1_m = 0;
      stat(32'hff);
      ddrsq_ctl_model_inst.send(4'h0, 3'h0, 13'h0100, 1'b1);
      stat(32'hff);
      repeat (10) @(posedge ck);
      lock_m = 1;
      stat(32'hff);
      $display("test dll switch done");
      // leveling on alternating lanes, with random levels and feedback width
      alldq = 1'($urandom_range(1, 0));
      av(1'b1, 5'h00, {31'h0, alldq});
      ddrsq_ctl_model_inst.send(4'h0, 3'h1, 13'h0080, 1'b1);
      mr1_m = 32'h80;
      stat(32'hff);
      check({16'h0, dq_oe_b}, 32'h0);
      ddrsq_ctl_model_inst.odt_set(1'b1);
      repeat (100) @(posedge mclk);
      check({30'h0, dqs_term, dq_term}, 32'h2);
      for (int i = 0; i < 8; i++) begin
         dly = $urandom_range(16, 2) + (($urandom_range(1, 0) == 1) ? 22 : 0);
         ddrsq_ctl_model_inst.pulse(i % 2, dly, lvl);
         fb[i % 2] = alldq ? {8{lvl}} : {7'h0, lvl};
         repeat (12) @(posedge mclk);
         check({16'h0, dq}, {16'h0, fb[1], fb[0]});
      end
      ddrsq_ctl_model_inst.odt_set(1'b0);
      repeat (100) @(posedge mclk);
      check({30'h0, dqs_term, dq_term}, 32'h0);
      // refresh is illegal while leveling; the error flag must catch it
      ddrsq_ctl_model_inst.send(4'h1, 3'h0, 13'h0, 1'b1);
      av(1'b0, 5'h10, 32'h0);
      check(rdata & 32'h2, 32'h2);
      v = ($urandom & 32'h1266) | 32'h0004;
      ddrsq_ctl_model_inst.send(4'h0, 3'h1, v[12:0], 1'b1);
      mr1_m = v;
      av(1'b0, 5'h0c, 32'h0);
      check(rdata, v);
      stat(32'hff);
      check({16'h0, dq_oe_b}, 32'hffff);
      $display("test leveling done");
      // power-down with nominal termination on, odt raised in error
      ddrsq_ctl_model_inst.send(4'h7, 3'h0, 13'h0, 1'b0);
      st_m = 4;
      free_m = 1;
      ddrsq_ctl_model_inst.odt_set(1'b1);
      repeat (100) @(posedge mclk);
      check({30'h0, dqs_term, dq_term}, 32'h0);
      stat(32'hef);
      ddrsq_ctl_model_inst.odt_set(1'b0);
      av(1'b0, 5'h10, 32'h0);
      check(rdata & 32'h4, 32'h4);
      av(1'b1, 5'h10, 32'h7);
      av(1'b0, 5'h10, 32'h0);
      check(rdata, 32'h0);
      ddrsq_ctl_model_inst.send(4'h7, 3'h0, 13'h0, 1'b1);
      st_m = 1;
      free_m = 0;
      stat(32'hef);
      $display("test power-down done");
      tally_and_finish();
   end
endmodule
